//--- rtl/ica_defs.svh
`ifndef ICA_DEFS_SVH
`define ICA_DEFS_SVH
// system clock period in ns
`define ICA_CLK_NS 100
// power-on command window in ms
`define ICA_WIN_MS 10
`define ICA_WIN_CYC ((`ICA_WIN_MS * 1000000) / `ICA_CLK_NS)
// command reply time in us
`define ICA_RESP_US 100
`define ICA_RESP_CYC ((`ICA_RESP_US * 1000) / `ICA_CLK_NS)
// memory write time in ms
`define ICA_WR_MS 12
`define ICA_WR_CYC ((`ICA_WR_MS * 1000000) / `ICA_CLK_NS)
// slave address after reset, config word offset and reset value
`define ICA_DEF_ADDR 7'h28
`define ICA_CFG_OFS 5'h1C
`define ICA_CFG_RST 16'h0028
// command codes and command pages (top three bits)
`define ICA_CMD_ENTER 8'hA0
`define ICA_CMD_NORMAL 8'h80
`define ICA_CMD_REV 8'hB0
`define ICA_PAGE_RD 3'h0
`define ICA_PAGE_WR 3'h2
// status field codes
`define ICA_ST_CMD 2'h2
`define ICA_ST_STALE 2'h1
// response field codes
`define ICA_RC_BUSY 2'h0
`define ICA_RC_ACK 2'h1
`define ICA_RC_NACK 2'h2
`endif

//--- rtl/ica_pkg.sv
package ica_pkg;
    // operating mode of the module
    typedef enum logic [1:0] {MODE_WINDOW, MODE_CMD, MODE_NORMAL} ica_mode_t;
    // bus-facing byte engine
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_RECV, BUS_ACK, BUS_SEND, BUS_MACK
    } ica_bus_t;
    // one received command message
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] data;
    } ica_msg_t;
    // first reply byte: status, diagnostic, response
    typedef struct packed {
        logic [1:0] status;
        logic [3:0] diag;
        logic [1:0] resp;
    } ica_reply_t;
endpackage

//--- rtl/ica_cmd_slave.sv
`timescale 1ns/1ns
`include "ica_defs.svh"
// Behaviour
// R01 - entry message only within 10 ms
// R02 - message is address, command, two data
// R03 - answer at address 0x28 by default
// R04 - 0xA0 enters command mode in window
// R05 - 0x1C reads, 0x5C writes config word
// R06 - master sends zero data on reads
// R07 - reply ready within 100 us
// R08 - status, diagnostic, response fields in byte
// R09 - diagnostic bits: corrected, fatal, parity, config
// R10 - memory read reply: status, high, low
// R11 - address in bits 6:0, default 0x28
// R12 - old address kept while in command mode
// R13 - success gives reply byte 0x81
// R14 - 0x00-0x1F reads memory word
// R15 - 0x40-0x5F writes memory, 12 ms
// R16 - 0x80 leaves command mode to normal
// R17 - 0xB0 places revision in reply
// R18 - fetch uses address with read bit
// R19 - master reads, modifies, writes config back
// R20 - master re-reads config to confirm
// R21 - master retries slower on failed entry; the testbench retries at the same 800 ns bus clock
// R22 - fetch returns bytes until master nacks
// R23 - first fetched bit set in command mode
// R24 - late entry rejected, normal operation continues
module ica_cmd_slave
    import ica_pkg::*;
#(
    parameter int unsigned WIN_CYC = `ICA_WIN_CYC,
    parameter int unsigned WR_CYC = `ICA_WR_CYC,
    // revision value is arbitrary
    parameter logic [7:0] REVISION = 8'h01
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [3:0] diag_in,
    output logic command_mode_flag,
    output logic normal_mode,
    output logic [6:0] slave_addr
);
    localparam int unsigned RESP_CYC = `ICA_RESP_CYC;
    localparam int unsigned MAXC = (WIN_CYC > WR_CYC) ? WIN_CYC : WR_CYC;
    localparam int CW = $clog2(MAXC + 1);

    // pin synchronisers: bit 0 first stage, bit 2 edge history
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    // bus engine state
    ica_bus_t bus_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic addr_phase_reg; // still waiting for address byte
    logic read_reg; // transfer is a fetch
    logic [1:0] rx_cnt_reg; // message bytes taken after address
    ica_msg_t msg_reg;
    logic [1:0] tx_idx_reg; // reply byte being sent
    logic mack_ok_reg; // master acked last reply byte
    logic cmd_go_reg; // one-cycle pulse: full message ended
    logic sda_out_reg;
    logic sda_oe_reg;
    // command engine state
    ica_mode_t mode_reg;
    logic [CW-1:0] win_cnt_reg;
    logic [CW-1:0] busy_cnt_reg;
    logic [1:0] resp_reg;
    logic [3:0] diag_reg;
    logic [15:0] rd_data_reg;
    logic wr_pend_reg;
    logic [4:0] wr_addr_reg;
    logic [15:0] wr_data_reg;
    logic [6:0] slave_addr_reg;
    logic command_mode_flag_reg;
    logic normal_mode_reg;
    logic [15:0] mem_reg [32]; // word store, reloaded with defaults on reset

    // decoded conditions
    logic sda_now, scl_rise, scl_fall, bus_start, bus_stop;
    logic idle, win_open, accept, data_zero, rd_page, wr_page, leave_cmd;
    logic [6:0] cfg_addr;
    ica_reply_t reply_c;
    logic [7:0] tx_byte;

    assign sda_now = sda_sync_reg[1];
    assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
    // start and stop: data moves while clock stays high
    assign bus_start = scl_sync_reg[1] & scl_sync_reg[2]
        & ~sda_sync_reg[1] & sda_sync_reg[2];
    assign bus_stop = scl_sync_reg[1] & scl_sync_reg[2]
        & sda_sync_reg[1] & ~sda_sync_reg[2];
    assign idle = busy_cnt_reg == '0;
    assign win_open = win_cnt_reg != '0;
    // messages arriving while a reply is pending are dropped
    assign accept = cmd_go_reg & idle;
    assign data_zero = msg_reg.data == 16'h0000;
    assign rd_page = msg_reg.cmd[7:5] == `ICA_PAGE_RD;
    assign wr_page = msg_reg.cmd[7:5] == `ICA_PAGE_WR;
    // R16 leave command
    assign leave_cmd = accept & mode_reg == MODE_CMD
        & msg_reg.cmd == `ICA_CMD_NORMAL & data_zero;
    // R11 address field
    assign cfg_addr = mem_reg[`ICA_CFG_OFS][6:0];
    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign command_mode_flag = command_mode_flag_reg;
    assign normal_mode = normal_mode_reg;
    assign slave_addr = slave_addr_reg;

    // reply byte from current mode and last outcome
    always_comb begin
        // R08 status fields
        // R23 top bit flags mode
        reply_c.status = (mode_reg == MODE_CMD) ? `ICA_ST_CMD : `ICA_ST_STALE;
        // R09 diagnostic bits
        reply_c.diag = diag_reg;
        reply_c.resp = resp_reg;
    end

    // R10 reply byte order
    always_comb begin
        case (tx_idx_reg)
            2'h0: tx_byte = reply_c;
            2'h1: tx_byte = rd_data_reg[15:8];
            2'h2: tx_byte = rd_data_reg[7:0];
            default: tx_byte = 8'h00; // past the reply: zeros
        endcase
    end

    // two-stage capture of the bus pins
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end else if (ce) begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
        end
    end

    // bus byte engine: address match, message bytes, reply bytes
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_reg <= BUS_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            addr_phase_reg <= 1'b0;
            read_reg <= 1'b0;
            rx_cnt_reg <= 2'h0;
            msg_reg <= '0;
            tx_idx_reg <= 2'h0;
            mack_ok_reg <= 1'b0;
            cmd_go_reg <= 1'b0;
            sda_out_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
        end else if (ce) begin
            cmd_go_reg <= 1'b0;
            if (bus_start) begin
                // a start always restarts address reception
                bus_reg <= BUS_RECV;
                bit_cnt_reg <= 4'h0;
                addr_phase_reg <= 1'b1;
                rx_cnt_reg <= 2'h0;
                sda_oe_reg <= 1'b0;
            end else if (bus_stop) begin
                bus_reg <= BUS_IDLE;
                sda_oe_reg <= 1'b0;
                // R02 four byte message
                if (!addr_phase_reg && !read_reg && rx_cnt_reg == 2'h3) begin
                    cmd_go_reg <= 1'b1;
                end
            end else begin
                unique case (bus_reg)
                    BUS_IDLE: begin
                        sda_oe_reg <= 1'b0;
                    end
                    BUS_RECV: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_now};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            if (addr_phase_reg) begin
                                // R03 address match
                                if (shift_reg[7:1] == slave_addr_reg) begin
                                    addr_phase_reg <= 1'b0;
                                    read_reg <= shift_reg[0];
                                    tx_idx_reg <= 2'h0;
                                    bus_reg <= BUS_ACK;
                                    sda_out_reg <= 1'b0;
                                    sda_oe_reg <= 1'b1;
                                end else begin
                                    bus_reg <= BUS_IDLE;
                                end
                            end else if (rx_cnt_reg != 2'h3) begin
                                case (rx_cnt_reg)
                                    2'h0: msg_reg.cmd <= shift_reg;
                                    2'h1: msg_reg.data[15:8] <= shift_reg;
                                    default: msg_reg.data[7:0] <= shift_reg;
                                endcase
                                rx_cnt_reg <= rx_cnt_reg + 2'h1;
                                bus_reg <= BUS_ACK;
                                sda_out_reg <= 1'b0;
                                sda_oe_reg <= 1'b1;
                            end else begin
                                // a fifth byte is not acknowledged
                                bus_reg <= BUS_IDLE;
                            end
                        end
                    end
                    BUS_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (read_reg) begin
                                // R18 fetch reply
                                shift_reg <= {tx_byte[6:0], 1'b0};
                                sda_out_reg <= tx_byte[7];
                                bus_reg <= BUS_SEND;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                bus_reg <= BUS_RECV;
                            end
                        end
                    end
                    BUS_SEND: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                sda_oe_reg <= 1'b0;
                                bus_reg <= BUS_MACK;
                                if (tx_idx_reg != 2'h3) begin
                                    tx_idx_reg <= tx_idx_reg + 2'h1;
                                end
                            end else begin
                                sda_out_reg <= shift_reg[7];
                                shift_reg <= {shift_reg[6:0], 1'b0};
                            end
                        end
                    end
                    BUS_MACK: begin
                        if (scl_rise) begin
                            mack_ok_reg <= ~sda_now;
                        end else if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            // R22 until master nack
                            if (mack_ok_reg) begin
                                shift_reg <= {tx_byte[6:0], 1'b0};
                                sda_out_reg <= tx_byte[7];
                                sda_oe_reg <= 1'b1;
                                bus_reg <= BUS_SEND;
                            end else begin
                                bus_reg <= BUS_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // operating mode and power-on window
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= MODE_WINDOW;
            win_cnt_reg <= CW'(WIN_CYC);
        end else if (ce) begin
            if (win_open) begin
                win_cnt_reg <= win_cnt_reg - 1'b1;
            end
            unique case (mode_reg)
                MODE_WINDOW: begin
                    // R01 entry window
                    if (accept && win_open
                        && msg_reg.cmd == `ICA_CMD_ENTER) begin
                        mode_reg <= MODE_CMD;
                    end else if (!win_open) begin
                        // R24 window lapsed
                        mode_reg <= MODE_NORMAL;
                    end
                end
                MODE_CMD: begin
                    if (leave_cmd) begin
                        mode_reg <= MODE_NORMAL;
                    end
                end
                MODE_NORMAL: begin
                    mode_reg <= MODE_NORMAL;
                end
            endcase
        end
    end

    // command execution, reply timer and reply contents
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_cnt_reg <= '0;
            resp_reg <= `ICA_RC_ACK;
            diag_reg <= 4'h0;
            rd_data_reg <= 16'h0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 5'h00;
            wr_data_reg <= 16'h0000;
        end else if (ce) begin
            if (!idle) begin
                // R07 reply timer
                busy_cnt_reg <= busy_cnt_reg - 1'b1;
                if (busy_cnt_reg == CW'(1)) begin
                    // R13 positive response
                    resp_reg <= `ICA_RC_ACK;
                    wr_pend_reg <= 1'b0;
                end
            end else if (cmd_go_reg) begin
                diag_reg <= diag_in;
                if (mode_reg == MODE_WINDOW && win_open
                    && msg_reg.cmd == `ICA_CMD_ENTER) begin
                    // R04 entry reply
                    busy_cnt_reg <= CW'(RESP_CYC - 1);
                    resp_reg <= `ICA_RC_BUSY;
                end else if (mode_reg == MODE_CMD) begin
                    if (msg_reg.cmd == `ICA_CMD_NORMAL && data_zero) begin
                        resp_reg <= `ICA_RC_ACK;
                    end else if (rd_page && data_zero) begin
                        // R14 memory read
                        // R05 config read
                        rd_data_reg <= mem_reg[msg_reg.cmd[4:0]];
                        busy_cnt_reg <= CW'(RESP_CYC - 1);
                        resp_reg <= `ICA_RC_BUSY;
                    end else if (wr_page) begin
                        // R15 memory write
                        wr_addr_reg <= msg_reg.cmd[4:0];
                        wr_data_reg <= msg_reg.data;
                        wr_pend_reg <= 1'b1;
                        busy_cnt_reg <= CW'(WR_CYC - 1);
                        resp_reg <= `ICA_RC_BUSY;
                    end else if (msg_reg.cmd == `ICA_CMD_REV && data_zero) begin
                        // R17 revision reply
                        rd_data_reg <= {8'h00, REVISION};
                        busy_cnt_reg <= CW'(RESP_CYC - 1);
                        resp_reg <= `ICA_RC_BUSY;
                    end else begin
                        // unknown code, or nonzero data with a read, 0x80 or 0xB0
                        resp_reg <= `ICA_RC_NACK;
                    end
                end else if (msg_reg.cmd == `ICA_CMD_ENTER) begin
                    // R24 late entry
                    resp_reg <= `ICA_RC_NACK;
                end
            end
        end
    end

    // word store; the write lands when its timer runs out
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                mem_reg[i] <= (i == `ICA_CFG_OFS) ? `ICA_CFG_RST : 16'h0000;
            end
        end else if (ce && wr_pend_reg && busy_cnt_reg == CW'(1)) begin
            mem_reg[wr_addr_reg] <= wr_data_reg;
        end
    end

    // active address: only replaced when command mode ends
    always_ff @(posedge clk) begin
        if (rst) begin
            slave_addr_reg <= `ICA_DEF_ADDR;
        end else if (ce && leave_cmd) begin
            // R12 address takes effect
            slave_addr_reg <= cfg_addr;
        end
    end

    // mode flags for the pins, one cycle behind the mode
    always_ff @(posedge clk) begin
        if (rst) begin
            command_mode_flag_reg <= 1'b0;
            normal_mode_reg <= 1'b0;
        end else if (ce) begin
            command_mode_flag_reg <= mode_reg == MODE_CMD;
            normal_mode_reg <= mode_reg == MODE_NORMAL;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst || !ce);

    // R04 entry honoured
    a_entry_window: assert property ( // R04
        (accept && mode_reg == MODE_WINDOW && win_open
            && msg_reg.cmd == `ICA_CMD_ENTER)
        |=> mode_reg == MODE_CMD && resp_reg == `ICA_RC_BUSY)
        else $error("entry command not honoured");
    // R24 late entry rejected
    a_late_entry: assert property ( // R24
        (accept && mode_reg == MODE_NORMAL && msg_reg.cmd == `ICA_CMD_ENTER)
        |=> mode_reg == MODE_NORMAL && resp_reg == `ICA_RC_NACK)
        else $error("late entry not rejected");
    // R01 window close
    a_window_close: assert property ( // R01
        (mode_reg == MODE_WINDOW && !win_open) |=> mode_reg == MODE_NORMAL)
        else $error("window lapsed without normal mode");
    // R07 reply timing
    a_reply_time: assert property ( // R07
        (accept && mode_reg == MODE_CMD && rd_page && data_zero)
        |=> (resp_reg == `ICA_RC_BUSY) [*8] ##[1:992]
            resp_reg == `ICA_RC_ACK)
        else $error("read reply not ready in time");
    // R15 write commit
    a_write_commit: assert property ( // R15
        $fell(wr_pend_reg) |-> mem_reg[wr_addr_reg] == wr_data_reg)
        else $error("memory word not written");
    // R15 busy while writing
    a_write_busy: assert property ( // R15
        wr_pend_reg |-> resp_reg == `ICA_RC_BUSY && !idle)
        else $error("write pending without busy reply");
    // R12 address held
    a_addr_hold: assert property ( // R12
        !leave_cmd |=> $stable(slave_addr_reg))
        else $error("address changed outside mode exit");
    // R16 address applied on exit
    a_addr_apply: assert property ( // R16
        leave_cmd |=> slave_addr_reg == $past(cfg_addr)
            && mode_reg == MODE_NORMAL)
        else $error("new address not applied on exit");
    // R03 default address
    a_reset_addr: assert property ( // R03
        $past(rst) |-> slave_addr_reg == `ICA_DEF_ADDR)
        else $error("default address missing after reset");
    // R03 ack only own address
    a_ack_match: assert property ( // R03
        ($past(bus_reg) == BUS_RECV && bus_reg == BUS_ACK
            && $past(addr_phase_reg))
        |-> $past(shift_reg[7:1]) == slave_addr_reg && sda_oe_reg)
        else $error("acknowledged a foreign address");
    // R23 first fetched bit
    a_fetch_flag: assert property ( // R23
        ($past(bus_reg) == BUS_ACK && bus_reg == BUS_SEND && tx_idx_reg == 2'h0)
        |-> sda_out_reg == (mode_reg == MODE_CMD))
        else $error("first fetched bit wrong");

    c_entry: cover property (mode_reg == MODE_WINDOW ##1 mode_reg == MODE_CMD);
    c_late: cover property (accept && mode_reg == MODE_NORMAL);
    c_write: cover property ($fell(wr_pend_reg));
    c_exit: cover property (leave_cmd);
endmodule // ica_cmd_slave

//--- verif/ica_mst.sv
`timescale 1ns/1ns
// bus master model: open-drain data, 800 ns bus clock
module ica_mst (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // a quarter of the bus clock, two system clocks
    task automatic qtr();
        repeat (2) @(posedge clk);
    endtask
    // one bit; sampling mid-high, well clear of slave changes
    task automatic xbit(input logic d, output logic q);
        sda_low <= !d;
        qtr();
        scl <= 1'b1;
        qtr();
        q = sda;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask
    task automatic start();
        sda_low <= 1'b0;
        scl <= 1'b1;
        qtr();
        sda_low <= 1'b1;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        qtr();
        scl <= 1'b1;
        qtr();
        sda_low <= 1'b0;
        qtr();
    endtask
    // byte out msb first, returns the acknowledge bit
    task automatic wbyte(input logic [7:0] b, output logic nak);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xbit(b[i], q);
        end
        xbit(1'b1, nak);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, b[i]);
        end
        xbit(last, q);
    endtask
    task automatic msg(input logic [6:0] a, input logic [23:0] c,
                       output logic [2:0] naks);
        logic n;
        naks = 3'h0;
        start();
        wbyte({a, 1'b0}, n);
        naks = naks + {2'h0, n};
        for (int i = 2; i >= 0; i--) begin
            wbyte(c[i*8 +: 8], n);
            naks = naks + {2'h0, n};
        end
        stop();
    endtask
    task automatic fetch(input logic [6:0] a, input int nb,
                         output logic nak, output logic [23:0] r);
        logic [7:0] b;
        r = 24'h000000;
        start();
        wbyte({a, 1'b1}, nak);
        for (int i = 0; i < nb && !nak; i++) begin
            rbyte(i == nb - 1, b);
            r[23-8*i -: 8] = b;
        end
        stop();
    endtask
endmodule // ica_mst

//--- verif/ica_cmd_slave_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; \
    if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ica_cmd_slave_tb_top;
    // shortened window and write time keep the run brief
    localparam int WIN = 2000;
    localparam int WRC = 1500;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] diag_in = 4'h0;
    logic ce = 1'b1;
    logic scl, sda_low, sda_out, sda_oe, command_mode_flag, normal_mode;
    logic [6:0] slave_addr;
    int n_mismatch = 0;
    int total_checks = 0;
    // open-drain wire with pull-up
    wire sda;
    assign sda = !((sda_oe && !sda_out) || sda_low);
    typedef struct {
        logic [7:0] cmd;
        logic [15:0] dat;
        logic [3:0] dg;
        logic [1:0] rs;
        int wt;
        int nb;
        logic [15:0] word;
    } ica_row_t;
    // reads carry zero data except row 9; command 0xFF marks a fetch-only row
    // rows 1-2 read the config word, then write it back
    // row 4 re-reads it to confirm the new address
    ica_row_t rows [11] = '{
        '{8'hA0, 16'h0000, 4'h0, 2'h1, 1100, 1, 16'h0000},
        '{8'h1C, 16'h0000, 4'h4, 2'h1, 1100, 3, 16'h0028},
        '{8'h5C, 16'h0031, 4'h0, 2'h0, 200, 1, 16'h0000},
        '{8'hFF, 16'h0000, 4'h0, 2'h1, 1500, 1, 16'h0000},
        '{8'h1C, 16'h0000, 4'h0, 2'h1, 1100, 3, 16'h0031},
        '{8'h45, 16'h1234, 4'h2, 2'h0, 200, 1, 16'h0000},
        '{8'hFF, 16'h0000, 4'h2, 2'h1, 1500, 1, 16'h0000},
        '{8'h05, 16'h0000, 4'h1, 2'h1, 1100, 3, 16'h1234},
        '{8'hB0, 16'h0000, 4'h8, 2'h1, 1100, 3, 16'h0001},
        '{8'h1C, 16'h0001, 4'h0, 2'h2, 1100, 1, 16'h0000},
        '{8'h60, 16'h0000, 4'h0, 2'h2, 1100, 1, 16'h0000}};
    ica_cmd_slave #(.WIN_CYC(WIN), .WR_CYC(WRC)) ica_cmd_slave_inst (
        .clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .diag_in(diag_in),
        .command_mode_flag(command_mode_flag), .normal_mode(normal_mode),
        .slave_addr(slave_addr));
    ica_mst ica_mst_inst (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    always #50 clk = ~clk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        logic [2:0] naks;
        logic nak;
        logic [23:0] r;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("reset addr", 7'h28, slave_addr)
        `CHK("reset oe", 1'b0, sda_oe)
        // table rows: message, wait, fetch, compare
        foreach (rows[i]) begin
            diag_in <= rows[i].dg;
            if (rows[i].cmd !== 8'hFF) begin
                ica_mst_inst.msg(7'h28, {rows[i].cmd, rows[i].dat}, naks);
                `CHK("msg naks", 3'h0, naks)
            end
            repeat (rows[i].wt) @(posedge clk);
            ica_mst_inst.fetch(7'h28, rows[i].nb, nak, r);
            `CHK("reply", {2'h2, rows[i].dg, rows[i].rs}, r[23:16])
            if (rows[i].nb == 3)
                `CHK("word", rows[i].word, r[15:0])
            $display("row %0d done", i);
        end
        // new address waits for the leave command
        `CHK("addr held", 7'h28, slave_addr)
        `CHK("cm flag", 1'b1, command_mode_flag)
        ica_mst_inst.msg(7'h28, 24'h800000, naks);
        repeat (5) @(posedge clk);
        `CHK("addr new", 7'h31, slave_addr)
        `CHK("normal", 1'b1, normal_mode)
        `CHK("cm off", 1'b0, command_mode_flag)
        ica_mst_inst.fetch(7'h31, 1, nak, r);
        `CHK("stale", 8'h41, r[23:16])
        ica_mst_inst.fetch(7'h28, 1, nak, r);
        `CHK("old addr nak", 1'b1, nak)
        $display("normal mode test done");
        // second reset; a low clock enable freezes the window
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ce <= 1'b0;
        repeat (WIN + 100) @(posedge clk);
        `CHK("ce freeze", 1'b0, normal_mode)
        ce <= 1'b1;
        repeat (WIN + 100) @(posedge clk);
        `CHK("addr again", 7'h28, slave_addr)
        `CHK("window shut", 1'b1, normal_mode)
        ica_mst_inst.msg(7'h28, 24'hA00000, naks);
        repeat (1100) @(posedge clk);
        ica_mst_inst.fetch(7'h28, 1, nak, r);
        `CHK("late entry", 8'h42, r[23:16])
        `CHK("cm late", 1'b0, command_mode_flag)
        $display("late entry test done");
        // failed entry: power-on again, retry inside the window
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        ica_mst_inst.msg(7'h28, 24'hA00000, naks);
        `CHK("retry naks", 3'h0, naks)
        repeat (1100) @(posedge clk);
        ica_mst_inst.fetch(7'h28, 1, nak, r);
        `CHK("retry entry", 8'h81, r[23:16])
        `CHK("cm retry", 1'b1, command_mode_flag)
        $display("retry entry test done");
        conclude();
    end
endmodule // ica_cmd_slave_tb_top
